// [sacl_cache.sv]
// Set-associative cache directory and data store with line fill and write posting.
`timescale 1ns/10ps
`default_nettype none
module sacl_cache
  import sacl_pkg::*;
#(
  parameter int WAYS = SACL_WAYS,
  parameter int SETS = SACL_SETS,
  parameter int LINE_WORDS = SACL_LINE_WORDS,
  parameter int ADDR_W = SACL_ADDR_W,
  parameter int CA_W = SACL_CA_W,
  parameter int REGION_SEL = SACL_REGION_SEL,
  parameter int SECTOR = SACL_SECTOR
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Configuration
  input wire logic post_en_in,
  // Processor request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_nocache_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [SACL_DATA_W-1:0] req_wdata_in,
  input wire logic [SACL_BE_W-1:0] req_be_in,
  output logic req_ready_out,
  // Processor answer
  output logic rsp_valid_out,
  output logic rsp_hit_out,
  output logic [SACL_DATA_W-1:0] rsp_data_out,
  // Memory read
  output logic mem_rd_req_out,
  output logic [ADDR_W-1:0] mem_rd_addr_out,
  input wire logic mem_rd_ack_in,
  input wire logic [SACL_DATA_W-1:0] mem_rd_data_in,
  // Memory write
  output logic mem_wr_valid_out,
  output logic [ADDR_W-1:0] mem_wr_addr_out,
  output logic [SACL_DATA_W-1:0] mem_wr_data_out,
  output logic [SACL_BE_W-1:0] mem_wr_be_out,
  input wire logic mem_wr_ready_in
);
  // -----------------------------------------------------------------------
  // Address layout
  // -----------------------------------------------------------------------
  // Index sits above the line offset, tag above the index; halving the
  // locations per way moves one bit from index to tag.
  localparam int LINE_LO = SACL_BYTE_W + $clog2(LINE_WORDS);
  localparam int TAG_LO = LINE_LO + $clog2(SETS);
  localparam int TAG_W = CA_W - TAG_LO;
  localparam int IX_W = (SETS > 1) ? $clog2(SETS) : 1;
  localparam int WO_W = (LINE_WORDS > 1) ? $clog2(LINE_WORDS) : 1;
  localparam int WY_W = (WAYS > 1) ? $clog2(WAYS) : 1;
  localparam logic [ADDR_W-1:0] WORD_STEP = ADDR_W'(SACL_WORD_BYTES);
  localparam logic [WO_W-1:0] LAST_WORD = WO_W'(LINE_WORDS - 1);
  localparam logic [WY_W-1:0] OLDEST = WY_W'(WAYS - 1);

  typedef struct packed {
    sacl_state_t st;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [SACL_DATA_W-1:0] wdata;
    logic [SACL_BE_W-1:0] be;
    logic cach;
    logic alloc;
    logic shit;
    logic [WY_W-1:0] way;
    logic [WO_W-1:0] cnt;
    logic [WO_W-1:0] last;
    logic rdy;
    logic rsp_v;
    logic rsp_hit;
    logic [SACL_DATA_W-1:0] rsp_d;
    logic rd_req;
    logic [ADDR_W-1:0] rd_addr;
    logic pv;
    logic [ADDR_W-1:0] paddr;
    logic [SACL_DATA_W-1:0] pdata;
    logic [SACL_BE_W-1:0] pbe;
  } sacl_ctl_t;

  sacl_ctl_t st_r;
  sacl_ctl_t st_nxt;

  // Directory, valid bits, ages and data words.
  logic [TAG_W-1:0] tag_mem [SETS][WAYS];
  logic [LINE_WORDS-1:0] vld_mem [SETS][WAYS];
  logic [WY_W-1:0] age_mem [SETS][WAYS];
  logic [SACL_DATA_W-1:0] dat_mem [SETS][WAYS][LINE_WORDS];

  logic [IX_W-1:0] idx;
  logic [TAG_W-1:0] tg;
  logic [WO_W-1:0] wo;
  logic [WAYS-1:0] hit_vec;
  logic [WY_W-1:0] hit_way;
  logic [WY_W-1:0] vic;
  logic vic_found;
  logic full_set;
  logic any_hit;
  logic wv;
  logic [SACL_DATA_W-1:0] hdata;
  logic region_ok;
  logic rd_hit;
  logic wcap;
  logic whit;
  logic fill_done;
  logic touch_en;
  logic [WY_W-1:0] touch_way;

  // -----------------------------------------------------------------------
  // Lookup of the latched request; region decode of the incoming one
  // -----------------------------------------------------------------------
  assign idx = IX_W'((st_r.addr >> LINE_LO) & (SETS - 1));
  assign tg = TAG_W'(st_r.addr >> TAG_LO);
  assign wo = WO_W'((st_r.addr >> SACL_BYTE_W) & (LINE_WORDS - 1));
  // Bits above the cached space select this memory or another.
  assign region_ok = ((req_addr_in >> CA_W) == ADDR_W'(REGION_SEL));

  // Every way's tag is compared in parallel; with one way this is a single
  // comparison, with one set it is the whole block address.
  always_comb begin
    hit_vec = '0;
    hit_way = '0;
    vic = '0;
    vic_found = 1'b0;
    full_set = 1'b1;
    for (int w = 0; w < WAYS; w++) begin
      hit_vec[w] = (|vld_mem[idx][w]) && (tag_mem[idx][w] == tg);
      if (hit_vec[w]) begin
        hit_way = WY_W'(w);
      end
      if (vld_mem[idx][w] == '0) begin
        full_set = 1'b0;
      end
    end
    // An empty way is taken first; otherwise the oldest age goes.
    for (int w = 0; w < WAYS; w++) begin
      if (!vic_found && (vld_mem[idx][w] == '0)) begin
        vic = WY_W'(w);
        vic_found = 1'b1;
      end
    end
    if (!vic_found) begin
      for (int w = 0; w < WAYS; w++) begin
        if (age_mem[idx][w] == OLDEST) begin
          vic = WY_W'(w);
        end
      end
    end
  end

  assign any_hit = |hit_vec;
  assign wv = vld_mem[idx][hit_way][wo]; // Per-block valid in sector mode.
  assign hdata = dat_mem[idx][hit_way][wo];
  assign rd_hit = (st_r.st == SACL_LOOK) && !st_r.wr && st_r.cach && any_hit && wv;
  assign wcap = (st_r.st == SACL_LOOK) && st_r.wr && !st_r.pv;
  assign whit = st_r.cach && any_hit && wv;
  assign fill_done = (st_r.st == SACL_FILL) && mem_rd_ack_in && (st_r.cnt == st_r.last);
  assign touch_en = rd_hit || (wcap && whit) || (fill_done && st_r.alloc);
  assign touch_way = (st_r.st == SACL_FILL) ? st_r.way : hit_way;

  // -----------------------------------------------------------------------
  // Control sequencing
  // -----------------------------------------------------------------------
  // The posted write drains independently; a new capture only happens when
  // the holder is empty, so a drain and a capture never collide.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_v = 1'b0;
    if (st_r.pv && mem_wr_ready_in) begin
      st_nxt.pv = 1'b0;
    end
    unique case (st_r.st)
      SACL_IDLE: begin
        if (req_valid_in && st_r.rdy) begin
          st_nxt.wr = req_write_in;
          st_nxt.addr = req_addr_in;
          st_nxt.wdata = req_wdata_in;
          st_nxt.be = req_be_in;
          st_nxt.cach = !req_nocache_in && region_ok;
          st_nxt.st = SACL_LOOK;
        end
      end
      SACL_LOOK: begin
        if (!st_r.wr) begin
          if (rd_hit) begin
            st_nxt.rsp_v = 1'b1;
            st_nxt.rsp_hit = 1'b1;
            st_nxt.rsp_d = hdata;
            st_nxt.st = SACL_IDLE;
          end else if (!st_r.pv) begin
            // A read miss waits for the posted write so memory is current.
            st_nxt.st = SACL_FILL;
            st_nxt.rd_req = 1'b1;
            st_nxt.rsp_hit = 1'b0;
            st_nxt.alloc = st_r.cach;
            st_nxt.shit = (SECTOR != 0) && st_r.cach && any_hit;
            st_nxt.way = any_hit ? hit_way : vic;
            // Sector mode fetches only the addressed block, tag hit or not.
            if (!st_r.cach || (SECTOR != 0)) begin
              st_nxt.cnt = wo;
              st_nxt.last = wo;
              st_nxt.rd_addr = ADDR_W'((st_r.addr >> SACL_BYTE_W) << SACL_BYTE_W);
            end else begin
              st_nxt.cnt = '0;
              st_nxt.last = LAST_WORD;
              st_nxt.rd_addr = ADDR_W'((st_r.addr >> LINE_LO) << LINE_LO);
            end
          end
        end else if (!st_r.pv) begin
          // Write-through: every write goes to the holder.
          st_nxt.pv = 1'b1;
          st_nxt.paddr = st_r.addr;
          st_nxt.pdata = st_r.wdata;
          st_nxt.pbe = st_r.be;
          st_nxt.rsp_hit = whit;
          st_nxt.rsp_d = '0;
          if (post_en_in) begin
            st_nxt.rsp_v = 1'b1;
            st_nxt.st = SACL_IDLE;
          end else begin
            st_nxt.st = SACL_WAIT;
          end
        end
      end
      SACL_FILL: begin
        if (mem_rd_ack_in) begin
          if (st_r.cnt == wo) begin
            st_nxt.rsp_d = mem_rd_data_in;
          end
          if (st_r.cnt == st_r.last) begin
            st_nxt.rd_req = 1'b0;
            st_nxt.rsp_v = 1'b1;
            st_nxt.st = SACL_IDLE;
          end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            st_nxt.rd_addr = st_r.rd_addr + WORD_STEP;
          end
        end
      end
      SACL_WAIT: begin
        if (st_r.pv && mem_wr_ready_in) begin
          st_nxt.rsp_v = 1'b1;
          st_nxt.st = SACL_IDLE;
        end
      end
    endcase
    st_nxt.rdy = (st_nxt.st == SACL_IDLE);
  end

  // Control register.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.st <= SACL_RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // Storage update
  // -----------------------------------------------------------------------
  // Ages form a permutation per set; the touched way becomes youngest and
  // only younger ways age, so the order stays a permutation.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int s = 0; s < SETS; s++) begin
        for (int w = 0; w < WAYS; w++) begin
          vld_mem[s][w] <= '0;
          age_mem[s][w] <= WY_W'(w);
        end
      end
    end else begin
      if (wcap && whit) begin
        for (int b = 0; b < SACL_BE_W; b++) begin
          if (st_r.be[b]) begin
            dat_mem[idx][hit_way][wo][8*b +: 8] <= st_r.wdata[8*b +: 8];
          end
        end
      end
      if ((st_r.st == SACL_FILL) && mem_rd_ack_in && st_r.alloc) begin
        dat_mem[idx][st_r.way][st_r.cnt] <= mem_rd_data_in;
        if (st_r.cnt == st_r.last) begin
          tag_mem[idx][st_r.way] <= tg;
          if (st_r.shit) begin
            vld_mem[idx][st_r.way][st_r.cnt] <= 1'b1;
          end else if (SECTOR != 0) begin
            vld_mem[idx][st_r.way] <= LINE_WORDS'(1) << st_r.cnt;
          end else begin
            vld_mem[idx][st_r.way] <= '1;
          end
        end
      end
      if (touch_en) begin
        for (int w = 0; w < WAYS; w++) begin
          if (WY_W'(w) == touch_way) begin
            age_mem[idx][w] <= '0;
          end else if (age_mem[idx][w] < age_mem[idx][touch_way]) begin
            age_mem[idx][w] <= age_mem[idx][w] + 1'b1;
          end
        end
      end
    end
  end

  // Outputs come straight from the control register.
  assign req_ready_out = st_r.rdy;
  assign rsp_valid_out = st_r.rsp_v;
  assign rsp_hit_out = st_r.rsp_hit;
  assign rsp_data_out = st_r.rsp_d;
  assign mem_rd_req_out = st_r.rd_req;
  assign mem_rd_addr_out = st_r.rd_addr;
  assign mem_wr_valid_out = st_r.pv;
  assign mem_wr_addr_out = st_r.paddr;
  assign mem_wr_data_out = st_r.pdata;
  assign mem_wr_be_out = st_r.pbe;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  // Helper state watched only by the checks below.
  logic [WO_W:0] beats_r;
  logic filled_r;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      beats_r <= '0;
      filled_r <= 1'b0;
    end else begin
      if (st_r.st != SACL_FILL) begin
        beats_r <= '0;
      end else if (mem_rd_ack_in) begin
        beats_r <= beats_r + 1'b1;
      end
      if (fill_done && st_r.alloc) begin
        filled_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_read_hit_data: assert property (rd_hit |=> rsp_valid_out && rsp_hit_out
    && (rsp_data_out == $past(hdata)))
    else $error("Read hit did not return the stored word.");
  a_tag_on_fill: assert property (fill_done && st_r.alloc |=>
    tag_mem[idx][$past(st_r.way)] == tg)
    else $error("Fill did not store the request tag.");
  a_hit_onehot: assert property ((st_r.st == SACL_LOOK) |-> $onehot0(hit_vec))
    else $error("More than one way hit.");
  a_sector_block: assert property ((st_r.st == SACL_FILL) && st_r.shit |->
    (st_r.last == wo) && (beats_r == '0))
    else $error("Sector refill fetched more than the missing block.");
  a_full_line: assert property (fill_done && st_r.alloc && !st_r.shit && (SECTOR == 0)
    |-> beats_r == (WO_W + 1)'(LINE_WORDS - 1))
    else $error("Line marked filled before all words arrived.");
  a_post_release: assert property (wcap && post_en_in |=>
    rsp_valid_out && mem_wr_valid_out && req_ready_out)
    else $error("Posted write did not release the processor.");
  a_lru_victim: assert property ((st_r.st == SACL_LOOK) && !st_r.wr && st_r.cach
    && !any_hit && !st_r.pv && full_set |=> age_mem[idx][st_r.way] == OLDEST)
    else $error("Victim is not the least recently used way.");
  a_write_forward: assert property (wcap && !post_en_in |=>
    mem_wr_valid_out && !rsp_valid_out)
    else $error("Unposted write answered before memory took it.");
  a_no_early_hit: assert property (rsp_hit_out |-> filled_r)
    else $error("Hit reported before any line was filled.");
  a_fill_stall: assert property ((st_r.st == SACL_FILL) |-> !req_ready_out
    ##1 (rsp_valid_out || !req_ready_out))
    else $error("Request accepted during an outstanding fill.");
endmodule // sacl_cache
`default_nettype wire

// [sacl_cache_note_end.sv]
// This file holds no code.

// [sacl_mem_model.sv]
// Behavioural main memory that answers the cache's line fills and posted writes.
`timescale 1ns/10ps
`default_nettype none
module sacl_mem_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Wait cycles before each answer
  input wire logic [7:0] lat_in,
  // Read port
  input wire logic mem_rd_req_in,
  input wire logic [31:0] mem_rd_addr_in,
  output logic mem_rd_ack_out,
  output logic [31:0] mem_rd_data_out,
  // Write port
  input wire logic mem_wr_valid_in,
  input wire logic [31:0] mem_wr_addr_in,
  input wire logic [31:0] mem_wr_data_in,
  input wire logic [3:0] mem_wr_be_in,
  output logic mem_wr_ready_out,
  // Observation for the bench
  output logic [15:0] rd_beats_out,
  output logic [15:0] wr_count_out,
  output logic [31:0] wr_addr_out,
  output logic [31:0] wr_data_out
);
  logic [31:0] mem [logic [31:0]];
  logic [7:0] rc;
  logic [7:0] wc;
  logic [3:0] wb;
  logic [31:0] word;

  // Untouched words hold an address pattern, so a wrong beat shows as wrong data.
  function automatic logic [31:0] rdw(input logic [31:0] a);
    if (mem.exists(a)) return mem[a];
    return {a[15:0] ^ 16'hC3A5, a[15:0]};
  endfunction

  // Answers change just after the falling edge, so the cache sees them settled.
  // Outside an acknowledge the data lines show the inverse of the last beat.
  always @(negedge core_clk_in) begin
    if (rst_in) begin
      mem.delete();
      rc = 8'h00;
      wc = 8'h00;
      mem_rd_ack_out <= 1'b0;
      mem_wr_ready_out <= 1'b0;
      mem_rd_data_out <= 32'h0000_0000;
      rd_beats_out <= 16'h0000;
      wr_count_out <= 16'h0000;
      wr_addr_out <= 32'h0000_0000;
      wr_data_out <= 32'h0000_0000;
    end else begin
      if (mem_rd_ack_out) begin
        mem_rd_ack_out <= 1'b0;
        mem_rd_data_out <= ~mem_rd_data_out;
        rc = 8'h00;
      end else if (mem_rd_req_in) begin
        if (rc >= lat_in) begin
          mem_rd_ack_out <= 1'b1;
          mem_rd_data_out <= rdw({mem_rd_addr_in[31:2], 2'b00});
          rd_beats_out <= rd_beats_out + 16'h0001;
        end else begin
          rc = rc + 8'h01;
        end
      end
      // A write is committed once ready has stood through a rising edge.
      if (mem_wr_ready_out) begin
        mem_wr_ready_out <= 1'b0;
        word = rdw(wr_addr_out);
        for (int i = 0; i < 4; i++) begin
          if (wb[i]) word[8*i +: 8] = wr_data_out[8*i +: 8];
        end
        mem[wr_addr_out] = word;
        wr_count_out <= wr_count_out + 16'h0001;
        wc = 8'h00;
      end else if (mem_wr_valid_in) begin
        if (wc >= lat_in) begin
          mem_wr_ready_out <= 1'b1;
          wr_addr_out <= {mem_wr_addr_in[31:2], 2'b00};
          wr_data_out <= mem_wr_data_in;
          wb = mem_wr_be_in;
        end else begin
          wc = wc + 8'h01;
        end
      end
    end
  end
endmodule // sacl_mem_model
`default_nettype wire

// [sacl_pkg.sv]
// Shared constants and types for the set-associative cache lookup block.
`default_nettype none
package sacl_pkg;
  // ---------------------------------------------------------------------
  // Organisation defaults
  // ---------------------------------------------------------------------
  localparam int SACL_WAYS = 4; // Four ways of 2 Kbyte each.
  localparam int SACL_SETS = 128; // Lines per way, seven index bits.
  localparam int SACL_LINE_WORDS = 4; // Sixteen bytes under one tag.
  localparam int SACL_ADDR_W = 32;
  localparam int SACL_CA_W = 32; // Width of the cached address space.
  localparam int SACL_REGION_SEL = 0; // Value of the bits above the cached space.
  localparam int SACL_SECTOR = 0; // One valid bit per word when set.
  localparam int SACL_DATA_W = 32;
  localparam int SACL_BE_W = 4;
  localparam int SACL_BYTE_W = 2; // Byte offset bits of a word.
  localparam int SACL_WORD_BYTES = 4;
  // ---------------------------------------------------------------------
  // Control states, Gray coded along idle, lookup, fill, write wait
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    SACL_IDLE = 2'h0,
    SACL_LOOK = 2'h1,
    SACL_FILL = 2'h3,
    SACL_WAIT = 2'h2
  } sacl_state_t;
  localparam sacl_state_t SACL_RST_STATE = SACL_IDLE;
endpackage : sacl_pkg
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the cache lookup block with a behavioural memory.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sacl_pkg::*;
  logic core_clk_in;
  logic rst_in;
  logic post_en_in;
  logic req_valid_in;
  logic req_write_in;
  logic req_nocache_in;
  logic [31:0] req_addr_in;
  logic [31:0] req_wdata_in;
  logic [3:0] req_be_in;
  logic req_ready_out;
  logic rsp_valid_out;
  logic rsp_hit_out;
  logic [31:0] rsp_data_out;
  logic mem_rd_req_out;
  logic [31:0] mem_rd_addr_out;
  logic mem_rd_ack_in;
  logic [31:0] mem_rd_data_in;
  logic mem_wr_valid_out;
  logic [31:0] mem_wr_addr_out;
  logic [31:0] mem_wr_data_out;
  logic [3:0] mem_wr_be_out;
  logic mem_wr_ready_in;
  logic [7:0] lat;
  logic [15:0] beats;
  logic [15:0] wrs;
  logic [31:0] wr_a;
  logic [31:0] wr_d;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  sacl_cache sacl_cache_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .post_en_in(post_en_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_nocache_in(req_nocache_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .req_be_in(req_be_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_hit_out(rsp_hit_out),
    .rsp_data_out(rsp_data_out), .mem_rd_req_out(mem_rd_req_out),
    .mem_rd_addr_out(mem_rd_addr_out), .mem_rd_ack_in(mem_rd_ack_in),
    .mem_rd_data_in(mem_rd_data_in), .mem_wr_valid_out(mem_wr_valid_out),
    .mem_wr_addr_out(mem_wr_addr_out), .mem_wr_data_out(mem_wr_data_out),
    .mem_wr_be_out(mem_wr_be_out), .mem_wr_ready_in(mem_wr_ready_in));

  sacl_mem_model sacl_mem_model_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .lat_in(lat),
    .mem_rd_req_in(mem_rd_req_out), .mem_rd_addr_in(mem_rd_addr_out),
    .mem_rd_ack_out(mem_rd_ack_in), .mem_rd_data_out(mem_rd_data_in),
    .mem_wr_valid_in(mem_wr_valid_out), .mem_wr_addr_in(mem_wr_addr_out),
    .mem_wr_data_in(mem_wr_data_out), .mem_wr_be_in(mem_wr_be_out),
    .mem_wr_ready_out(mem_wr_ready_in), .rd_beats_out(beats), .wr_count_out(wrs),
    .wr_addr_out(wr_a), .wr_data_out(wr_d));

  // ---------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  // The whole run needs a few hundred cycles; a hang is cut well after that.
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'hC3A5, a[15:0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One request, entered at a falling edge; n counts edges from taking to answer.
  task automatic acc(input logic w, input logic nc, input logic [31:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic h, output logic [31:0] q,
    output int n);
    int g;
    logic stall_bad;
    g = 0;
    stall_bad = 1'b0;
    req_valid_in = 1'b1;
    req_write_in = w;
    req_nocache_in = nc;
    req_addr_in = a;
    req_wdata_in = d;
    req_be_in = be;
    while (req_ready_out !== 1'b1 && g < 200) begin
      @(negedge core_clk_in);
      g++;
    end
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
    n = 1; // The taking edge counts as the first.
    while (rsp_valid_out !== 1'b1 && n < 300) begin
      if (req_ready_out !== 1'b0) stall_bad = 1'b1;
      @(negedge core_clk_in);
      n++;
    end
    h = rsp_hit_out;
    q = rsp_data_out;
    check({31'h0, stall_bad}, 32'h0);
    check({31'h0, rsp_valid_out}, 32'h1);
  endtask

  // A read whose hit, data and number of memory beats are all judged.
  task automatic rd(input logic [31:0] a, input logic eh, input logic [31:0] ed,
    input logic nc);
    logic h;
    logic [31:0] q;
    int n;
    logic [15:0] b0;
    b0 = beats;
    acc(1'b0, nc, a, 32'h0, 4'hF, h, q, n);
    check({31'h0, h}, {31'h0, eh});
    check(q, ed);
    check({16'h0, beats - b0}, eh ? 32'h0 : (nc ? 32'h1 : 32'h4));
    if (eh) check(n, 32'h2);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_fill;
    lat = 8'h03;
    rd(32'h0000_0100, 1'b0, pat(32'h0000_0100), 1'b0);
    rd(32'h0000_010C, 1'b1, pat(32'h0000_010C), 1'b0);
    rd(32'h0000_0110, 1'b0, pat(32'h0000_0110), 1'b0);
    $display("TB: fill and hit done");
  endtask

  // Five lines 2 Kbyte apart share one index; the fifth evicts the oldest.
  task automatic t_ways;
    logic [31:0] a [5];
    lat = 8'h00;
    for (int k = 0; k < 5; k++) a[k] = 32'h0000_2040 + 32'(k) * 32'h0000_0800;
    for (int k = 0; k < 4; k++) rd(a[k], 1'b0, pat(a[k]), 1'b0);
    for (int k = 0; k < 4; k++) rd(a[k], 1'b1, pat(a[k]), 1'b0);
    rd(a[0], 1'b1, pat(a[0]), 1'b0);
    rd(a[4], 1'b0, pat(a[4]), 1'b0);
    rd(a[0], 1'b1, pat(a[0]), 1'b0);
    rd(a[2], 1'b1, pat(a[2]), 1'b0);
    rd(a[3], 1'b1, pat(a[3]), 1'b0);
    rd(a[1], 1'b0, pat(a[1]), 1'b0);
    $display("TB: ways and replacement done");
  endtask

  // Use-once data is marked non-cacheable, so it never allocates.
  task automatic t_nocache;
    rd(32'h0000_3000, 1'b0, pat(32'h0000_3000), 1'b1);
    rd(32'h0000_3000, 1'b0, pat(32'h0000_3000), 1'b1);
    $display("TB: non-cacheable done");
  endtask

  task automatic t_writes;
    logic h;
    logic [31:0] q;
    int n;
    int g;
    logic [15:0] w0;
    lat = 8'h06;
    post_en_in = 1'b1;
    w0 = wrs;
    acc(1'b1, 1'b0, 32'h0000_0104, 32'hDEAD_BEEF, 4'hF, h, q, n);
    check(n, 32'h2);
    check({31'h0, h}, 32'h1);
    check({16'h0, wrs}, {16'h0, w0});
    g = 0;
    while (wrs === w0 && g < 100) begin
      @(negedge core_clk_in);
      g++;
    end
    check(wr_a, 32'h0000_0104);
    check(wr_d, 32'hDEAD_BEEF);
    rd(32'h0000_0104, 1'b1, 32'hDEAD_BEEF, 1'b0);
    acc(1'b1, 1'b0, 32'h0000_0108, 32'h1234_5678, 4'h3, h, q, n);
    rd(32'h0000_0108, 1'b1, (pat(32'h0000_0108) & 32'hFFFF_0000) | 32'h0000_5678, 1'b0);
    post_en_in = 1'b0;
    w0 = wrs;
    acc(1'b1, 1'b0, 32'h0000_010C, 32'hCAFE_0001, 4'hF, h, q, n);
    check({31'h0, n > 2}, 32'h1);
    // The memory counts the write at the edge where the answer is seen, so wait one.
    @(negedge core_clk_in);
    check({16'h0, wrs}, {16'h0, w0 + 16'h0002});
    acc(1'b1, 1'b0, 32'h0000_5000, 32'h0BAD_F00D, 4'hF, h, q, n);
    check({31'h0, h}, 32'h0);
    rd(32'h0000_5000, 1'b0, 32'h0BAD_F00D, 1'b0);
    $display("TB: writes done");
  endtask

  task automatic print_verdict;
    $display("TB: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    post_en_in = 1'b0;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_nocache_in = 1'b0;
    req_addr_in = 32'h0000_0000;
    req_wdata_in = 32'h0000_0000;
    req_be_in = 4'h0;
    lat = 8'h00;
    repeat (4) @(negedge core_clk_in);
    rst_in = 1'b0;
    @(negedge core_clk_in);
    t_fill();
    t_ways();
    t_nocache();
    t_writes();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
